// ---- src/cesp_regs.vh ----
// Constants for the configuration store programmer
`ifndef CESP_REGS_VH
`define CESP_REGS_VH

// Store geometry
`define CESP_WORDS        32
`define CESP_WORD_W       16
`define CESP_DATA_BITS    512
`define CESP_SUM_W        21
`define CESP_CMD_W        12
`define CESP_OP_W         5
`define CESP_CNT_W        10

// Supply-line levels presented to the external driver
`define CESP_LVL_OFF      2'h0
`define CESP_LVL_IDLE     2'h1
`define CESP_LVL_ONE      2'h2
`define CESP_LVL_ZERO     2'h3

// Fixed command frames (bit 0 sent first)
`define CESP_CMD_WR_PSI   12'h204
`define CESP_CMD_RD_PSI   12'h108

// Timing, in nanoseconds
`define CESP_CLK_NS       25
`define CESP_T_PHASE_NS   20000
`define CESP_T_ENTRY_NS   200000
`define CESP_T_OFF_NS     1000000
`define CESP_T_WDOG_NS    12000000

// Timer width
`define CESP_TMR_W        24

`endif

// ---- src/cesp_buf2.v ----
// Two-entry valid/ready buffer carrying words toward the link
`default_nettype none

module cesp_buf2 #(
  parameter W = 16
) (
  input  wire         sys_clk,
  input  wire         reset,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem_r [0:1];
  reg         wp_r;
  reg         rp_r;
  reg [1:0]   cnt_r;
  wire        push;
  wire        pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge sys_clk) begin
    if (reset) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

endmodule

`default_nettype wire

// ---- src/cesp_host.v ----
// Programmer that writes and reads the configuration store over its pins
`include "cesp_regs.vh"
`default_nettype none

// Summary of operation
// - Raise supply to idle level to enter
// - Enter between 200 us and 12 ms
// - One is high level, zero low
// - Bit 20 us, idle 20 us between
// - Five opcode, two address, mirrored opcode
// - Finish session before watchdog expiry (code aborts at T_WDOG_CYC and sets timeout; 545 bits need about 21.8 ms)
// - Pins: enable, clock, data, address/readback
// - Enable pin high before supply applied (code sets it on the same edge as the idle supply level)
// - Active and inactive phases 20 us each
// - Drop supply after write before reading
// - Command, 512 data bits LSB first, checksum
// - Fixed frame for write on mode pin
// - Each read clock gives next stored bit
// - Fixed frame for readback on mode pin
// - Checksum is 21-bit sum of words
module cesp_host #(
  parameter T_ENTRY_CYC = (`CESP_T_ENTRY_NS + `CESP_CLK_NS - 1) / `CESP_CLK_NS,
  parameter T_OFF_CYC   = (`CESP_T_OFF_NS + `CESP_CLK_NS - 1) / `CESP_CLK_NS,
  parameter T_WDOG_CYC  = `CESP_T_WDOG_NS / `CESP_CLK_NS
) (
  input  wire                    sys_clk,
  input  wire                    reset,
  // User side
  input  wire                    start,
  input  wire                    op_read,
  input  wire                    pin_mode,
  input  wire [`CESP_OP_W-1:0]   opcode,
  input  wire                    addr_bit,
  input  wire                    wr_valid,
  output wire                    wr_ready,
  input  wire [`CESP_WORD_W-1:0] wr_data,
  output reg                     rd_valid,
  output reg  [`CESP_WORD_W-1:0] rd_data,
  output reg  [`CESP_SUM_W-1:0]  rd_sum,
  output reg                     rd_sum_ok,
  output reg                     busy,
  output reg                     done,
  output reg                     timeout,
  // Device pins
  output reg  [1:0]              supply_level,
  output reg                     programming_enable_pin,
  output reg                     first_general_pin_o,
  output reg                     second_general_pin_o,
  output reg                     third_general_pin_o,
  output reg                     third_general_pin_oe,
  input  wire                    third_general_pin_i
);

  localparam PHASE_CYC = (`CESP_T_PHASE_NS + `CESP_CLK_NS - 1) / `CESP_CLK_NS;

  localparam S_IDLE  = 7'h01;
  localparam S_PWR   = 7'h02;
  localparam S_CMD   = 7'h04;
  localparam S_WDATA = 7'h08;
  localparam S_RDATA = 7'h10;
  localparam S_OFF   = 7'h20;
  localparam S_DONE  = 7'h40;

  reg  [6:0]              state_r;
  reg  [6:0]              state_nxt;
  reg  [`CESP_TMR_W-1:0]  tmr_r;
  reg  [`CESP_TMR_W-1:0]  wdog_r;
  reg                     act_r;
  reg  [`CESP_CNT_W-1:0]  bit_r;
  reg  [`CESP_CMD_W-1:0]  cmd_r;
  reg  [`CESP_WORD_W-1:0] sh_r;
  reg  [`CESP_SUM_W-1:0]  sum_r;
  reg                     bitv_r;
  reg                     pin_r;
  reg                     rd_r;
  reg                     sync1_r;
  reg                     sync2_r;
  wire                    buf_valid;
  wire [`CESP_WORD_W-1:0] buf_data;
  reg                     buf_take;
  wire                    phase_end;
  wire [`CESP_CNT_W-1:0]  rd_idx;

  // Mirrored command frame, bit 0 sent first
  function [`CESP_CMD_W-1:0] mk_cmd;
    input [`CESP_OP_W-1:0] op;
    input                  a;
    begin
      mk_cmd = {op[0], op[1], op[2], op[3], op[4], a, a, op};
    end
  endfunction

  function [`CESP_SUM_W-1:0] add_word;
    input [`CESP_SUM_W-1:0]  s;
    input [`CESP_WORD_W-1:0] w;
    begin
      add_word = s + {{(`CESP_SUM_W-`CESP_WORD_W){1'b0}}, w};
    end
  endfunction

  cesp_buf2 #(
    .W (`CESP_WORD_W)
  ) u_buf (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (buf_valid),
    .out_ready (buf_take),
    .out_data  (buf_data)
  );

  // ---------------------------------------------------------------
  // Read-back pin synchroniser
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= third_general_pin_i;
      sync2_r <= sync1_r;
    end
  end

  assign phase_end = (tmr_r == {`CESP_TMR_W{1'b0}});
  assign rd_idx    = bit_r - {{(`CESP_CNT_W-1){1'b0}}, 1'b1};

  // Word boundary in write stream needs a buffered word
  always @* begin
    buf_take = 1'b0;
    if (state_r == S_WDATA && phase_end && !act_r && bit_r[3:0] == 4'hF &&
        bit_r < `CESP_DATA_BITS) begin
      buf_take = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (start) begin
          state_nxt = S_PWR;
        end
      end
      S_PWR: begin
        if (phase_end) begin
          state_nxt = S_CMD;
        end
      end
      S_CMD: begin
        if (phase_end && act_r && bit_r == `CESP_CMD_W - 1) begin
          state_nxt = rd_r ? S_RDATA : S_WDATA;
        end
      end
      S_WDATA: begin
        if (phase_end && !act_r && bit_r == `CESP_DATA_BITS + `CESP_SUM_W) begin
          state_nxt = S_OFF;
        end
      end
      S_RDATA: begin
        if (phase_end && !act_r && bit_r == `CESP_DATA_BITS + `CESP_SUM_W + 1) begin
          state_nxt = S_OFF;
        end
      end
      S_OFF: begin
        if (phase_end) begin
          state_nxt = S_DONE;
        end
      end
      S_DONE: begin
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    if ((state_r & (S_CMD | S_WDATA | S_RDATA)) != 7'h00 && wdog_r == T_WDOG_CYC) begin
      state_nxt = S_OFF;
    end
  end

  // Bit to send in the current active phase
  always @* begin
    bitv_r = 1'b0;
    if (state_r == S_CMD) begin
      bitv_r = cmd_r[bit_r[3:0]];
    end else if (bit_r < `CESP_DATA_BITS) begin
      bitv_r = sh_r[0];
    end else begin
      bitv_r = sum_r[bit_r - `CESP_DATA_BITS];
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      state_r                <= S_IDLE;
      tmr_r                  <= {`CESP_TMR_W{1'b0}};
      wdog_r                 <= {`CESP_TMR_W{1'b0}};
      act_r                  <= 1'b0;
      bit_r                  <= {`CESP_CNT_W{1'b0}};
      cmd_r                  <= {`CESP_CMD_W{1'b0}};
      sh_r                   <= {`CESP_WORD_W{1'b0}};
      sum_r                  <= {`CESP_SUM_W{1'b0}};
      pin_r                  <= 1'b0;
      rd_r                   <= 1'b0;
      rd_valid               <= 1'b0;
      rd_data                <= {`CESP_WORD_W{1'b0}};
      rd_sum                 <= {`CESP_SUM_W{1'b0}};
      rd_sum_ok              <= 1'b0;
      busy                   <= 1'b0;
      done                   <= 1'b0;
      timeout                <= 1'b0;
      supply_level           <= `CESP_LVL_OFF;
      programming_enable_pin <= 1'b0;
      first_general_pin_o    <= 1'b0;
      second_general_pin_o   <= 1'b0;
      third_general_pin_o    <= 1'b0;
      third_general_pin_oe   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      if (!phase_end) begin
        tmr_r <= tmr_r - {{(`CESP_TMR_W-1){1'b0}}, 1'b1};
      end
      if ((state_r & (S_CMD | S_WDATA | S_RDATA)) != 7'h00) begin
        wdog_r <= wdog_r + {{(`CESP_TMR_W-1){1'b0}}, 1'b1};
      end
      case (state_r)
        S_IDLE: begin
          if (start) begin
            busy    <= 1'b1;
            timeout <= 1'b0;
            pin_r   <= pin_mode;
            rd_r    <= op_read;
            wdog_r  <= {`CESP_TMR_W{1'b0}};
            bit_r   <= {`CESP_CNT_W{1'b0}};
            act_r   <= 1'b0;
            sum_r   <= {`CESP_SUM_W{1'b0}};
            cmd_r   <= mk_cmd(opcode, addr_bit);
            tmr_r   <= T_ENTRY_CYC[`CESP_TMR_W-1:0];
            if (pin_mode) begin
              programming_enable_pin <= 1'b1;
            end
            // Address level stands on the third pin during the command
            third_general_pin_o  <= addr_bit;
            third_general_pin_oe <= 1'b1;
            supply_level <= `CESP_LVL_IDLE;
          end
        end
        S_PWR: begin
          if (phase_end) begin
            tmr_r <= PHASE_CYC[`CESP_TMR_W-1:0];
          end
        end
        S_CMD, S_WDATA, S_RDATA: begin
          if (phase_end) begin
            tmr_r <= PHASE_CYC[`CESP_TMR_W-1:0];
            if (!act_r) begin
              // Bit presented after the previous read clock, settled by now
              if (state_r == S_RDATA && bit_r != {`CESP_CNT_W{1'b0}}) begin
                if (rd_idx < `CESP_DATA_BITS) begin
                  sh_r <= {sync2_r, sh_r[`CESP_WORD_W-1:1]};
                  if (rd_idx[3:0] == 4'hF) begin
                    rd_data  <= {sync2_r, sh_r[`CESP_WORD_W-1:1]};
                    rd_valid <= 1'b1;
                    sum_r    <= add_word(sum_r, {sync2_r, sh_r[`CESP_WORD_W-1:1]});
                  end
                end else if (rd_idx < `CESP_DATA_BITS + `CESP_SUM_W) begin
                  rd_sum <= {sync2_r, rd_sum[`CESP_SUM_W-1:1]};
                end else begin
                  rd_sum_ok <= (rd_sum == sum_r) & ~sync2_r;
                end
              end
              if (state_nxt != state_r) begin
                act_r <= 1'b0;
              end else if (state_r == S_WDATA && bit_r[3:0] == 4'h0 &&
                           bit_r < `CESP_DATA_BITS && !buf_valid) begin
                tmr_r <= {`CESP_TMR_W{1'b0}};
              end else begin
                act_r <= 1'b1;
                if (state_r == S_WDATA && bit_r[3:0] == 4'h0 && bit_r < `CESP_DATA_BITS) begin
                  sh_r  <= buf_data;
                  sum_r <= add_word(sum_r, buf_data);
                end
                if (pin_r && state_r != S_RDATA) begin
                  second_general_pin_o <= (state_r == S_CMD) ? cmd_r[bit_r[3:0]] :
                                          (bit_r[3:0] == 4'h0 && bit_r < `CESP_DATA_BITS) ?
                                          buf_data[0] : bitv_r;
                  first_general_pin_o  <= 1'b1;
                end else if (pin_r) begin
                  first_general_pin_o <= 1'b1;
                end else if (state_r == S_RDATA) begin
                  supply_level <= `CESP_LVL_ONE;
                end else begin
                  supply_level <= ((state_r == S_WDATA && bit_r[3:0] == 4'h0 &&
                                    bit_r < `CESP_DATA_BITS) ? buf_data[0] : bitv_r) ?
                                  `CESP_LVL_ONE : `CESP_LVL_ZERO;
                end
              end
            end else begin
              act_r               <= 1'b0;
              supply_level        <= `CESP_LVL_IDLE;
              first_general_pin_o <= 1'b0;
              bit_r <= (state_nxt != state_r) ? {`CESP_CNT_W{1'b0}} :
                       bit_r + {{(`CESP_CNT_W-1){1'b0}}, 1'b1};
              if (state_r == S_WDATA && bit_r < `CESP_DATA_BITS) begin
                sh_r <= {1'b0, sh_r[`CESP_WORD_W-1:1]};
              end
              // Release the third pin so the store can answer on it
              if (state_r == S_CMD && state_nxt == S_RDATA) begin
                third_general_pin_oe <= 1'b0;
              end
            end
          end
        end
        S_OFF: begin
          if (state_r != state_nxt || tmr_r == {`CESP_TMR_W{1'b0}}) begin
            tmr_r <= T_OFF_CYC[`CESP_TMR_W-1:0];
          end
          supply_level           <= `CESP_LVL_OFF;
          programming_enable_pin <= 1'b0;
          first_general_pin_o    <= 1'b0;
          second_general_pin_o   <= 1'b0;
          third_general_pin_oe   <= 1'b0;
          act_r                  <= 1'b0;
          if (wdog_r == T_WDOG_CYC) begin
            timeout <= 1'b1;
          end
        end
        S_DONE: begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        default: begin
          busy <= 1'b0;
        end
      endcase
      if (state_nxt == S_OFF && state_r != S_OFF) begin
        tmr_r <= T_OFF_CYC[`CESP_TMR_W-1:0];
        if (wdog_r == T_WDOG_CYC) begin
          timeout <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- tb/cesp_host_assertions.sv ----
// Port checks for the configuration store programmer
`include "cesp_regs.vh"
`default_nettype none
module cesp_host_assertions #(
  parameter T_ENTRY_CYC = 8000,
  parameter T_OFF_CYC   = 40000,
  parameter T_WDOG_CYC  = 480000
) (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       start,
  input wire logic       busy,
  input wire logic       done,
  input wire logic [1:0] supply_level,
  input wire logic       programming_enable_pin,
  input wire logic       first_general_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ---------------------------------------------
  // Run lengths of supply-on, off, active and gap
  // ---------------------------------------------
  logic        off, act, seen;
  logic [23:0] up_c, off_c, act_c, gap_c;
  assign off = supply_level == `CESP_LVL_OFF;
  assign act = programming_enable_pin ? first_general_pin_o : supply_level[1];
  always @(posedge sys_clk) begin
    if (reset) begin
      up_c  <= 24'h0;
      off_c <= 24'h0;
      act_c <= 24'h0;
      gap_c <= 24'h0;
      seen  <= 1'b0;
    end else begin
      up_c  <= off ? 24'h0 : up_c + 24'h1;
      off_c <= off ? off_c + 24'h1 : 24'h0;
      act_c <= act ? act_c + 24'h1 : 24'h0;
      gap_c <= act ? 24'h0 : gap_c + 24'h1;
      seen  <= !off && (seen || act);
    end
  end
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  property p_enter;
    start && !busy |=> busy && supply_level == `CESP_LVL_IDLE;
  endproperty
  a_enter: assert property (p_enter) else $error("no idle level after start");
  property p_entry;
    act && !seen |-> up_c >= T_ENTRY_CYC && up_c < T_WDOG_CYC;
  endproperty
  a_entry: assert property (p_entry) else $error("entry wait wrong");
  property p_act;
    !act && act_c != 24'h0 && !off |-> act_c >= 800;
  endproperty
  a_act: assert property (p_act) else $error("active phase short");
  property p_gap;
    act && seen && gap_c != 24'h0 |-> gap_c >= 800;
  endproperty
  a_gap: assert property (p_gap) else $error("idle phase short");
  property p_wdog;
    !off |-> up_c <= T_ENTRY_CYC + T_WDOG_CYC + 4;
  endproperty
  a_wdog: assert property (p_wdog) else $error("session overran bound");
  property p_done;
    done |-> off && off_c >= T_OFF_CYC - 1;
  endproperty
  a_done: assert property (p_done) else $error("done before power-off wait");
  property p_enable;
    $changed(programming_enable_pin) |-> off || $past(off);
  endproperty
  a_enable: assert property (p_enable) else $error("enable moved while powered");
  property p_pinlvl;
    programming_enable_pin |-> !supply_level[1];
  endproperty
  a_pinlvl: assert property (p_pinlvl) else $error("supply bits in pin mode");
endmodule

bind cesp_host cesp_host_assertions #(
  .T_ENTRY_CYC (T_ENTRY_CYC),
  .T_OFF_CYC   (T_OFF_CYC),
  .T_WDOG_CYC  (T_WDOG_CYC)
) chk_u (
  .sys_clk                (sys_clk),
  .reset                  (reset),
  .start                  (start),
  .busy                   (busy),
  .done                   (done),
  .supply_level           (supply_level),
  .programming_enable_pin (programming_enable_pin),
  .first_general_pin_o    (first_general_pin_o)
);
`default_nettype wire

// ---- tb/cesp_dev_model.sv ----
// Behavioural model of the configuration store at its programming pins
`include "cesp_regs.vh"
`default_nettype none
module cesp_dev_model #(
  parameter int WDOG = 31000
) (
  input  wire logic       sys_clk,
  input  wire logic [1:0] supply_level,
  input  wire logic       enable_pin,
  input  wire logic       clk_pin,
  input  wire logic       data_pin,
  input  wire logic       addr_pin,
  output var  logic       out_pin,
  output var  logic       out_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0]  store [32];
  logic [532:0] wbuf;
  logic [11:0]  frame;
  logic [20:0]  ssum, wsum;
  logic [1:0]   lvl_q, lvl_qq;
  logic         clk_q, pin_mode, cmd_ok, dec, bit_ev, bit_v, ok, rd_cmd, addr_q;
  int           nbits, age;
  // ---------------------------------------------
  // Bit decode, registered once back at idle
  // ---------------------------------------------
  assign bit_ev = pin_mode ? clk_q & ~clk_pin : lvl_qq[1] && lvl_q == `CESP_LVL_IDLE;
  assign bit_v  = pin_mode ? data_pin : lvl_qq == `CESP_LVL_ONE;
  assign ok     = frame[4:0] == {frame[7], frame[8], frame[9], frame[10], frame[11]}
                  && frame[6:5] == {2{addr_q}};
  assign rd_cmd = frame[4:0] inside {5'h05, 5'h06, 5'h07, 5'h08};
  always_comb begin
    ssum = 21'h0;
    wsum = 21'h0;
    for (int i = 0; i < 32; i++) begin
      ssum += 21'(store[i]);
      wsum += 21'(wbuf[i*16 +: 16]);
    end
  end
  initial begin
    out_oe = 1'b0;
    for (int i = 0; i < 32; i++) store[i] = 16'(i * 16'h0841);
  end
  always @(posedge sys_clk) begin
    lvl_q  <= supply_level;
    lvl_qq <= lvl_q;
    clk_q  <= clk_pin;
    if (supply_level == `CESP_LVL_OFF) begin
      age    <= 0;
      nbits  <= 0;
      dec    <= 1'b0;
      cmd_ok <= 1'b0;
      out_oe <= 1'b0;
    end else begin
      age <= age + 1;
      if (age == 0) pin_mode <= enable_pin;
      if (bit_ev && age < WDOG) begin
        nbits <= nbits + 1;
        // Address level latched while the address bits arrive
        if (nbits == 5) addr_q <= addr_pin;
        if (nbits < 12) frame[nbits] <= bit_v;
        else if (nbits < 545) wbuf[nbits-12] <= bit_v;
        if (out_oe) out_pin <= nbits < 524 ? store[(nbits-12)/16][(nbits-12)%16]
                               : nbits < 545 ? ssum[nbits-524] : 1'b0;
      end
      if (nbits == 12 && !dec) begin
        dec     <= 1'b1;
        cmd_ok  <= ok;
        out_oe  <= ok && rd_cmd;
        out_pin <= 1'b1;
      end
      if (nbits == 545 && cmd_ok && !rd_cmd && wsum == wbuf[532:512])
        for (int i = 0; i < 32; i++) store[i] <= wbuf[i*16 +: 16];
    end
  end
endmodule
`default_nettype wire

// ---- tb/cesp_host_tb_top.sv ----
// Self-checking bench for the configuration store programmer
`include "cesp_regs.vh"
`default_nettype none
module cesp_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WDOG = 31000;
  localparam int LIM  = 40000;
  localparam int HWDOG = 23000;
  logic        sys_clk  = 1'b0;
  logic        reset    = 1'b1;
  logic        start    = 1'b0;
  logic        op_read  = 1'b0;
  logic        pin_mode = 1'b0;
  logic        addr_bit = 1'b0;
  logic        wr_valid = 1'b0;
  logic [4:0]  opcode   = 5'h00;
  logic [15:0] wr_data  = 16'h0000;
  logic [1:0]  supply_level;
  logic        wr_ready, busy, timeout, en_pin, clk_pin, dat_pin, p3o, p3oe, p3_last;
  logic        dev_o, dev_oe, done_o;
  wire logic   p3_w;
  int          n_errors = 0;
  int          checks   = 0;
  int          n_acc    = 0;

  cesp_host #(
    .T_OFF_CYC  (100),
    .T_WDOG_CYC (HWDOG)
  ) dut_u (
    .sys_clk                (sys_clk),
    .reset                  (reset),
    .start                  (start),
    .op_read                (op_read),
    .pin_mode               (pin_mode),
    .opcode                 (opcode),
    .addr_bit               (addr_bit),
    .wr_valid               (wr_valid),
    .wr_ready               (wr_ready),
    .wr_data                (wr_data),
    .rd_valid               (),
    .rd_data                (),
    .rd_sum                 (),
    .rd_sum_ok              (),
    .busy                   (busy),
    .done                   (done_o),
    .timeout                (timeout),
    .supply_level           (supply_level),
    .programming_enable_pin (en_pin),
    .first_general_pin_o    (clk_pin),
    .second_general_pin_o   (dat_pin),
    .third_general_pin_o    (p3o),
    .third_general_pin_oe   (p3oe),
    .third_general_pin_i    (p3_w)
  );
  cesp_dev_model #(.WDOG(WDOG)) dev_u (
    .sys_clk      (sys_clk),
    .supply_level (supply_level),
    .enable_pin   (en_pin),
    .clk_pin      (clk_pin),
    .data_pin     (dat_pin),
    .addr_pin     (p3_w),
    .out_pin      (dev_o),
    .out_oe       (dev_oe)
  );
  // Undriven address line shows the inverse of its last level
  assign p3_w = p3oe ? p3o : dev_oe ? dev_o : ~p3_last;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) p3_last <= p3_w;
  always @(posedge sys_clk) begin
    if (wr_valid && wr_ready) begin
      n_acc   <= n_acc + 1;
      wr_data <= 16'h1234 + 16'(n_acc);
    end
  end
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("Error at %0t ns: %s", $time, what);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge sys_clk);
    #1;
    n++;
    if (n > LIM) begin
      chk(1'b0, "wait bound exceeded");
      finish_test();
    end
  endtask
  // ---------------------------------------------
  // One session, ended by the watchdog bound
  // ---------------------------------------------
  task automatic session(input logic pm, rd, input logic [4:0] op, input logic ab,
                         input logic [11:0] fr);
    int n;
    n = 0;
    @(posedge sys_clk);
    reset    <= 1'b1;
    wr_valid <= 1'b0;
    repeat (8) @(posedge sys_clk);
    reset    <= 1'b0;
    pin_mode <= pm;
    op_read  <= rd;
    opcode   <= op;
    addr_bit <= ab;
    @(posedge sys_clk);
    start    <= 1'b1;
    wr_valid <= !rd;
    wr_data  <= 16'h8002;
    n_acc    <= 0;
    @(posedge sys_clk);
    start <= 1'b0;
    while (supply_level[1] !== 1'b1 && clk_pin !== 1'b1) tick(n);
    chk(n >= 7999 && n < 480000, "entry delay");
    @(posedge sys_clk) start <= 1'b1;
    @(posedge sys_clk) start <= 1'b0;
    while (dev_u.nbits < 12) tick(n);
    tick(n);
    chk(dev_u.frame === fr, "command frame");
    chk(en_pin === pm && dev_u.pin_mode === pm, "entry method");
    chk(dev_u.cmd_ok === 1'b1, "address bits");
    if (rd) chk(p3oe !== 1'b1, "read pin not released");
    else chk(n_acc == 2, "buffer not full before data");
    if (rd) begin
      while (dev_u.nbits < 13) tick(n);
      while (supply_level !== `CESP_LVL_ONE) tick(n);
      chk(dut_u.sh_r[15] === dev_u.store[0][0], "first read bit");
    end
    if (!rd) begin
      while (dev_u.nbits < 14) tick(n);
      chk(dev_u.wbuf[1:0] === 2'b10, "word bit order");
    end
    while (busy !== 1'b0) tick(n);
    chk(timeout === 1'b1 && supply_level === `CESP_LVL_OFF, "watchdog abort");
    chk(done_o === 1'b1, "no done after power-off wait");
    $display("session %h done", fr);
  endtask
  initial begin
    session(1'b0, 1'b0, 5'h04, 1'b0, `CESP_CMD_WR_PSI);
    session(1'b0, 1'b1, 5'h08, 1'b0, `CESP_CMD_RD_PSI);
    session(1'b1, 1'b0, 5'h01, 1'b1, 12'h861);
    finish_test();
  end
endmodule
`default_nettype wire
